// ---- dps_port_ctrl.sv ----
// Controller for one port of a dual-port memory with hardware semaphores.
//
// Design decisions made here: the plain strobed port and the address map.
`timescale 1ns/1ns
`default_nettype none
// Operation
// RULE1: Device picks master or slave from select.
// RULE2: Slave uses busy only as write inhibit.
// RULE3: Exactly one master part per array.
// RULE4: Master busy ignores read or write.
// RULE5: Hold address and enable before write strobe.
// RULE6: Eight shared semaphore latches exist.
// RULE7: Write zero requests, write one releases.
// RULE8: Semaphore chosen by three low address bits.
// RULE9: Semaphore write uses data bit zero only.
// RULE10: Free token taken shows zero to taker.
// RULE11: Owner writing one frees the token.
// RULE12: Other side's zero waits in request latch.
// RULE13: Pending request takes token on release.
// RULE14: Semaphore read spreads flag over all bits.
// RULE15: Read value latched while select and enable.
// RULE16: Drop select or enable between polls.
// RULE17: Acquire by write zero then read back.
// RULE18: After failure keep reading or write one.
// RULE19: Simultaneous requests give one winner.
// RULE20: Software frees all semaphores at power-up.
// RULE21: Flags gate no hardware resource.
// RULE22: No select means port in standby.
// RULE23: Later port gets busy on master.
// RULE24: Writes suppressed while busy driven low.
// RULE25: Simultaneous requests resolve to fixed priority.
module dps_port_ctrl (
  input wire logic clk,
  input wire logic sys_rst,
  input wire logic [7:0] reg_addr,
  input wire logic [31:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [31:0] reg_rdata,
  output dps_pkg::dps_pins_s pins,
  output logic master_select,
  input wire logic [dps_pkg::DPS_DATA_W-1:0] data_in,
  input wire logic busy_n
);
  import dps_pkg::*;

  dps_state_e state; // Access engine state.
  logic [3:0] cnt; // Cycles spent in the current phase.
  logic [2:0] op; // Command being carried out.
  logic [2:0] idx; // Semaphore index of the command.
  logic withdraw; // Withdraw at once after a failed request.
  logic [1:0] step; // Position within the command's access sequence.
  logic [7:0] polls; // Read-backs made after a failed request.
  logic acc_write; // Current access is a write.
  logic acc_sem; // Current access targets the semaphore space.
  logic acc_val; // Value written to a semaphore.
  logic [DPS_ADDR_W-1:0] mem_addr; // Memory address register.
  logic [DPS_DATA_W-1:0] mem_wdata; // Memory write data register.
  logic [DPS_DATA_W-1:0] rdata; // Last value read from the device.
  logic [DPS_SEM_COUNT-1:0] owned; // Semaphores this port holds.
  logic last_ok; // Last command succeeded.
  logic busy_seen; // A memory write had to wait for busy.
  logic start; // A command is accepted this cycle.

  // A command is accepted only while the engine is idle.
  assign start = reg_wr && (reg_addr == DPS_REG_CMD) && (state == DPS_IDLE)
    && (reg_wdata[DPS_CMD_OP_LSB +: 3] >= DPS_OP_INIT)
    && (reg_wdata[DPS_CMD_OP_LSB +: 3] <= DPS_OP_MEM_WRITE);

  // Operand registers written by software.
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      mem_addr <= DPS_ADDR_RESET;
      mem_wdata <= DPS_WDATA_RESET;
    end else if (reg_wr && reg_addr == DPS_REG_ADDR) begin
      mem_addr <= reg_wdata[DPS_ADDR_W-1:0];
    end else if (reg_wr && reg_addr == DPS_REG_WDATA) begin
      mem_wdata <= reg_wdata[DPS_DATA_W-1:0];
    end
  end

  // Read data appear the cycle after the read strobe; unmapped offsets read zero.
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      reg_rdata <= 32'h0000_0000;
    end else if (reg_rd) begin
      case (reg_addr)
        DPS_REG_ADDR: reg_rdata <= {17'h00000, mem_addr};
        DPS_REG_WDATA: reg_rdata <= {24'h000000, mem_wdata};
        DPS_REG_STATUS: begin
          reg_rdata <= 32'h0000_0000;
          reg_rdata[DPS_ST_RUN_BIT] <= (state != DPS_IDLE);
          reg_rdata[DPS_ST_OK_BIT] <= last_ok;
          reg_rdata[DPS_ST_BUSY_BIT] <= busy_seen;
          reg_rdata[DPS_ST_OWNED_LSB +: DPS_SEM_COUNT] <= owned;
          reg_rdata[DPS_ST_RDATA_LSB +: DPS_DATA_W] <= rdata;
        end
        default: reg_rdata <= 32'h0000_0000;
      endcase
    end else begin
      reg_rdata <= 32'h0000_0000;
    end
  end

  // This controller is strapped as the array's only master.
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      master_select <= 1'b1; // RULE3
    end else begin
      master_select <= 1'b1; // RULE3
    end
  end

  // Access engine: drives the pins through setup, strobe and gap phases.
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      state <= DPS_IDLE;
      cnt <= 4'h0;
      op <= 3'h0;
      idx <= 3'h0;
      withdraw <= 1'b0;
      step <= 2'h0;
      polls <= 8'h00;
      acc_write <= 1'b0;
      acc_sem <= 1'b0;
      acc_val <= 1'b1;
      rdata <= 8'h00;
      owned <= DPS_OWNED_RESET;
      last_ok <= 1'b0;
      busy_seen <= 1'b0;
      pins <= DPS_PINS_IDLE;
    end else begin
      case (state)
        // Wait for a command; the port stays in standby meanwhile.
        DPS_IDLE: begin
          pins <= DPS_PINS_IDLE; // RULE22
          if (start) begin
            op <= reg_wdata[DPS_CMD_OP_LSB +: 3];
            withdraw <= reg_wdata[DPS_CMD_WITHDRAW_BIT];
            step <= 2'h0;
            polls <= 8'h00;
            busy_seen <= 1'b0;
            cnt <= 4'h0;
            state <= DPS_SETUP;
            acc_sem <= reg_wdata[DPS_CMD_OP_LSB +: 3] <= DPS_OP_RELEASE;
            acc_write <= reg_wdata[DPS_CMD_OP_LSB +: 3] != DPS_OP_MEM_READ;
            // Initialisation frees every semaphore, starting at index zero.
            if (reg_wdata[DPS_CMD_OP_LSB +: 3] == DPS_OP_INIT) begin
              idx <= 3'h0; // RULE20
              acc_val <= 1'b1; // RULE20
            end else begin
              idx <= reg_wdata[DPS_CMD_IDX_LSB +: 3];
              // Acquire writes zero first, release writes one.
              acc_val <= reg_wdata[DPS_CMD_OP_LSB +: 3] != DPS_OP_ACQUIRE; // RULE17
            end
          end
        end
        // Address and selects stand before any strobe.
        DPS_SETUP: begin
          pins.addr <= acc_sem ? {12'h000, idx} : mem_addr;
          pins.chip_enable_n <= acc_sem;
          pins.semaphore_select_n <= !acc_sem;
          pins.data_oe <= acc_write;
          pins.data_out <= acc_sem ? {7'h00, acc_val} : mem_wdata;
          if (cnt < DPS_PHASE_CYC) begin
            cnt <= cnt + 4'h1;
          end else if (acc_write && !acc_sem && !busy_n) begin
            // The master has flagged busy; hold the strobe until it clears.
            busy_seen <= 1'b1; // RULE5
          end else begin
            cnt <= 4'h0;
            if (acc_write) begin
              pins.read_write_n <= 1'b0; // RULE5
              state <= DPS_WRITE;
            end else begin
              pins.output_enable_n <= 1'b0;
              state <= DPS_READ;
            end
          end
        end
        // Write strobe held for one phase.
        DPS_WRITE: begin
          if (cnt < DPS_PHASE_CYC) begin
            cnt <= cnt + 4'h1;
          end else begin
            cnt <= 4'h0;
            pins <= DPS_PINS_IDLE;
            state <= DPS_GAP;
          end
        end
        // Read phase; data are taken at its end.
        DPS_READ: begin
          if (cnt < DPS_PHASE_CYC) begin
            cnt <= cnt + 4'h1;
          end else begin
            cnt <= 4'h0;
            rdata <= data_in;
            pins <= DPS_PINS_IDLE; // RULE16
            state <= DPS_GAP;
          end
        end
        // All selects inactive, so the next read latches a fresh value.
        DPS_GAP: begin
          if (cnt < DPS_PHASE_CYC) begin
            cnt <= cnt + 4'h1; // RULE16
          end else begin
            cnt <= 4'h0;
            state <= DPS_NEXT;
          end
        end
        // Choose the next access of the command, or finish it.
        DPS_NEXT: begin
          state <= DPS_IDLE;
          last_ok <= 1'b1;
          case (op)
            DPS_OP_INIT: begin
              if (idx != DPS_SEM_LAST) begin
                idx <= idx + 3'h1; // RULE20
                state <= DPS_SETUP;
              end
              owned <= DPS_OWNED_RESET;
            end
            DPS_OP_ACQUIRE: begin
              if (step == 2'h0) begin
                // The request was written; now read it back.
                step <= 2'h1; // RULE17
                acc_write <= 1'b0;
                state <= DPS_SETUP;
              end else if (step == 2'h1) begin
                if (!rdata[0]) begin
                  owned[idx] <= 1'b1; // RULE17
                end else if (withdraw || polls == DPS_POLL_MAX) begin
                  // Give up: withdraw the pending request with a one.
                  step <= 2'h2; // RULE18
                  acc_write <= 1'b1;
                  acc_val <= 1'b1; // RULE18
                  state <= DPS_SETUP;
                end else begin
                  // Keep polling so a granted token is never left unused.
                  polls <= polls + 8'h01; // RULE18
                  state <= DPS_SETUP;
                end
              end else begin
                last_ok <= 1'b0;
              end
            end
            DPS_OP_RELEASE: owned[idx] <= 1'b0;
            default: last_ok <= 1'b1;
          endcase
        end
        default: begin
          state <= DPS_IDLE;
          pins <= DPS_PINS_IDLE;
        end
      endcase
    end
  end
endmodule // dps_port_ctrl
`default_nettype wire

// ---- dps_pkg.sv ----
// Package of constants and types for the dual-port semaphore port controller.
`default_nettype none
package dps_pkg;
  // Register offsets of the controller's own command and status port.
  localparam logic [7:0] DPS_REG_CMD = 8'h00;
  localparam logic [7:0] DPS_REG_ADDR = 8'h04;
  localparam logic [7:0] DPS_REG_WDATA = 8'h08;
  localparam logic [7:0] DPS_REG_STATUS = 8'h0c;
  // Command register field positions.
  localparam int DPS_CMD_OP_LSB = 0;
  localparam int DPS_CMD_IDX_LSB = 4;
  localparam int DPS_CMD_WITHDRAW_BIT = 8;
  // Status register field positions.
  localparam int DPS_ST_RUN_BIT = 0;
  localparam int DPS_ST_OK_BIT = 1;
  localparam int DPS_ST_BUSY_BIT = 2;
  localparam int DPS_ST_OWNED_LSB = 8;
  localparam int DPS_ST_RDATA_LSB = 16;
  // Command opcodes.
  localparam logic [2:0] DPS_OP_INIT = 3'h1;
  localparam logic [2:0] DPS_OP_ACQUIRE = 3'h2;
  localparam logic [2:0] DPS_OP_RELEASE = 3'h3;
  localparam logic [2:0] DPS_OP_MEM_READ = 3'h4;
  localparam logic [2:0] DPS_OP_MEM_WRITE = 3'h5;
  // Device geometry.
  localparam int DPS_ADDR_W = 15;
  localparam int DPS_DATA_W = 8;
  localparam int DPS_SEM_COUNT = 8;
  localparam logic [2:0] DPS_SEM_LAST = 3'h7;
  // Reset values.
  localparam logic [DPS_ADDR_W-1:0] DPS_ADDR_RESET = 15'h0000;
  localparam logic [DPS_DATA_W-1:0] DPS_WDATA_RESET = 8'h00;
  localparam logic [DPS_SEM_COUNT-1:0] DPS_OWNED_RESET = 8'h00;
  // Timing: every pin phase lasts at least this long.
  localparam int DPS_CLK_MHZ = 125;
  localparam int DPS_PHASE_NS = 40;
  localparam int DPS_PHASE_CYC_I = (DPS_PHASE_NS * DPS_CLK_MHZ + 999) / 1000;
  localparam logic [3:0] DPS_PHASE_CYC = DPS_PHASE_CYC_I[3:0];
  // Number of extra read-backs after a failed request before withdrawing.
  localparam logic [7:0] DPS_POLL_MAX = 8'h10;
  // Pin bundle driven toward one port of the memory.
  typedef struct packed {
    logic [DPS_ADDR_W-1:0] addr;
    logic [DPS_DATA_W-1:0] data_out;
    logic data_oe;
    logic chip_enable_n;
    logic semaphore_select_n;
    logic output_enable_n;
    logic read_write_n;
  } dps_pins_s;
  localparam dps_pins_s DPS_PINS_IDLE = '{addr: 15'h0000, data_out: 8'h00, data_oe: 1'b0,
    chip_enable_n: 1'b1, semaphore_select_n: 1'b1, output_enable_n: 1'b1, read_write_n: 1'b1};
  // Access engine states.
  typedef enum logic [2:0] {DPS_IDLE, DPS_SETUP, DPS_WRITE, DPS_READ, DPS_GAP, DPS_NEXT} dps_state_e;
endpackage
`default_nettype wire

// ---- dps_port_ctrl_props.sv ----
// Checker of the port controller's pin and register-port timing.
`timescale 1ns/1ns
`default_nettype none
module dps_port_ctrl_props (
  input wire logic clk,
  input wire logic sys_rst,
  input wire logic reg_rd,
  input wire logic [31:0] reg_rdata,
  input wire dps_pkg::dps_pins_s pins,
  input wire logic master_select,
  input wire logic busy_n
);
  import dps_pkg::*;
  // Every check uses the one clock and sleeps while reset is high.
  default clocking cb @(posedge clk); endclocking
  default disable iff (sys_rst);
  chk_one_master: assert property (master_select == 1'b1)
    else $error("master strap is not high");
  chk_write_setup: assert property ($fell(pins.read_write_n) |-> $past(pins.addr, 3) == pins.addr
    && $past(pins.chip_enable_n, 3) == pins.chip_enable_n
    && $past(pins.semaphore_select_n, 3) == pins.semaphore_select_n)
    else $error("write strobe began before address and selects settled");
  chk_busy_wait: assert property ($fell(pins.read_write_n) && !pins.chip_enable_n
    |-> $past(busy_n) || $past(busy_n, 2))
    else $error("memory write strobe began while busy was low");
  chk_poll_gap: assert property ($rose(pins.output_enable_n) && $past(pins.semaphore_select_n) == 1'b0
    |-> (pins.semaphore_select_n && pins.output_enable_n) [*3])
    else $error("semaphore read not followed by a deselected gap");
  chk_select_excl: assert property (pins.chip_enable_n || pins.semaphore_select_n)
    else $error("memory and semaphore selected together");
  chk_read_float: assert property (!pins.output_enable_n |-> !pins.data_oe)
    else $error("controller drives data during a read");
  chk_sem_wdata: assert property (!pins.semaphore_select_n && !pins.read_write_n
    |-> pins.data_oe && pins.data_out[7:1] == 7'h00)
    else $error("semaphore write carries stray upper data bits");
  chk_rdata_pulse: assert property (!$past(reg_rd) |-> reg_rdata == 32'h00000000)
    else $error("read data present without a read strobe");
endmodule // dps_port_ctrl_props
bind dps_port_ctrl dps_port_ctrl_props dps_port_ctrl_props_i (.clk(clk), .sys_rst(sys_rst),
  .reg_rd(reg_rd), .reg_rdata(reg_rdata), .pins(pins), .master_select(master_select),
  .busy_n(busy_n));
`default_nettype wire

// ---- dps_dev_model.sv ----
// Behavioural model of the dual-port memory with semaphores, left port at the pins.
`timescale 1ns/1ns
`default_nettype none
module dps_dev_model (
  input wire logic clk,
  input wire dps_pkg::dps_pins_s pins,
  input wire logic r_sem_wr,
  input wire logic [2:0] r_idx,
  input wire logic r_val,
  input wire logic r_ce,
  input wire logic [14:0] r_addr,
  output logic [dps_pkg::DPS_DATA_W-1:0] data_in,
  output logic busy_n
);
  import dps_pkg::*;
  logic [7:0] lreq = 8'h5a; // Request latches power up at no set level.
  logic [7:0] rreq = 8'h00;
  logic [7:0] own_l = 8'h00;
  logic [7:0] own_r = 8'h00;
  logic [7:0] nl;
  logic [7:0] nr;
  logic [7:0] no;
  logic [7:0] mem [0:15];
  logic [7:0] sem_q = 8'hff;
  logic rd_was = 1'b0;
  logic r_early = 1'b0;
  wire lsem = !pins.semaphore_select_n && pins.chip_enable_n;
  // Only the three low address bits and data bit zero reach the latches.
  always_comb begin
    nl = lreq;
    nr = rreq;
    if (lsem && !pins.read_write_n) nl[pins.addr[2:0]] = !pins.data_out[0];
    if (r_sem_wr) nr[r_idx] = !r_val;
    no = nl & ~(own_r & nr);
  end
  // Latches, token owner, read latch and memory; flags gate nothing.
  always @(posedge clk) begin
    lreq <= nl;
    rreq <= nr;
    own_l <= no;
    own_r <= nr & ~no;
    r_early <= pins.chip_enable_n ? r_ce : r_early;
    rd_was <= lsem && !pins.output_enable_n;
    if (lsem && !pins.output_enable_n && !rd_was) sem_q <= {8{!own_l[pins.addr[2:0]]}};
    if (!pins.chip_enable_n && !pins.read_write_n && busy_n) mem[pins.addr[3:0]] <= pins.data_out;
    if (lsem && !pins.output_enable_n) data_in <= sem_q;
    else if (!pins.chip_enable_n && !pins.output_enable_n) data_in <= mem[pins.addr[3:0]];
    else data_in <= ~data_in; // Undriven lines keep toggling.
  end
  // Busy on the left when the right reached the address first.
  assign busy_n = !(!pins.chip_enable_n && r_early && r_ce && r_addr == pins.addr);
  initial data_in = 8'h00;
endmodule // dps_dev_model
`default_nettype wire

// ---- testbench.sv ----
// Self-checking testbench of the semaphore port controller.
`timescale 1ns/1ns
`default_nettype none
module testbench;
  import dps_pkg::*;
  logic clk = 1'b0;
  logic sys_rst = 1'b1;
  logic [7:0] reg_addr = 8'h00;
  logic [31:0] reg_wdata = 32'h0;
  logic reg_wr = 1'b0;
  logic reg_rd = 1'b0;
  logic [31:0] reg_rdata;
  dps_pins_s pins;
  logic master_select;
  logic [7:0] data_in;
  logic busy_n;
  logic r_sem_wr = 1'b0;
  logic [2:0] r_idx = 3'h0;
  logic r_val = 1'b1;
  logic r_ce = 1'b0;
  logic [14:0] r_addr = 15'h0;
  int fail_count = 0;
  int checks_done = 0;
  int seed = 32'h2314;
  logic [31:0] st;
  logic [7:0] own_exp = 8'h00;
  logic [7:0] wd;
  logic [2:0] idx;
  logic held;
  logic [14:0] ra; // Address that both ports aim at in the busy scenario.
  // Clock of 8 ns period.
  always #4 clk = ~clk;
  dps_port_ctrl dps_port_ctrl_i (.clk(clk), .sys_rst(sys_rst), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
    .pins(pins), .master_select(master_select), .data_in(data_in), .busy_n(busy_n));
  dps_dev_model dps_dev_model_i (.clk(clk), .pins(pins), .r_sem_wr(r_sem_wr), .r_idx(r_idx),
    .r_val(r_val), .r_ce(r_ce), .r_addr(r_addr), .data_in(data_in), .busy_n(busy_n));
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    checks_done++;
    if (seen !== exp) begin
      fail_count++;
      $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task automatic give_verdict;
    $display("checks=%0d mismatches=%0d", checks_done, fail_count);
    if (fail_count == 0 && checks_done > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge clk);
    reg_wr <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] a, output logic [31:0] d);
    @(posedge clk);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge clk);
    reg_rd <= 1'b0;
    #1 d = reg_rdata;
  endtask
  // Polls the run bit under a bound; st keeps the last status.
  task automatic wait_idle;
    int n;
    for (n = 0; n < 3000; n++) begin
      rd(DPS_REG_STATUS, st);
      if (st[DPS_ST_RUN_BIT] === 1'b0) break;
    end
    if (n == 3000) begin
      check(32'h1, 32'h0);
      give_verdict();
    end
  endtask
  // The right-hand processor writes one semaphore.
  task automatic rsem(input logic [2:0] i, input logic v);
    @(posedge clk);
    r_idx <= i;
    r_val <= v;
    r_sem_wr <= 1'b1;
    @(posedge clk);
    r_sem_wr <= 1'b0;
  endtask
  function automatic logic [31:0] cmd(input logic [2:0] op, input logic [2:0] i, input logic w);
    return (32'(op) << DPS_CMD_OP_LSB) | (32'(i) << DPS_CMD_IDX_LSB) | (32'(w) << DPS_CMD_WITHDRAW_BIT);
  endfunction
  initial begin
    repeat (12) @(posedge clk);
    sys_rst <= 1'b0;
    rd(DPS_REG_STATUS, st);
    check(st, 32'h0);
    // After reset the port must rest in standby with the master strap high.
    check(pins, DPS_PINS_IDLE);
    check(master_select, 1'b1);
    rd(8'h10, st);
    check(st, 32'h0);
    wr(DPS_REG_CMD, 32'h7);
    rd(DPS_REG_STATUS, st);
    check(st[DPS_ST_RUN_BIT], 1'b0);
    $display("test register port done");
    for (int i = 0; i < 8; i++) rsem(3'(i), 1'b1);
    wr(DPS_REG_CMD, cmd(DPS_OP_INIT, 3'h0, 1'b0));
    wait_idle();
    check(dps_dev_model_i.lreq, 8'h00);
    $display("test init done");
    repeat (10) begin
      idx = 3'($random(seed));
      held = 1'($random(seed)) & !own_exp[idx];
      if (held) rsem(idx, 1'b0);
      wr(DPS_REG_CMD, cmd(DPS_OP_ACQUIRE, idx, 1'($random(seed))));
      wait_idle();
      own_exp[idx] = own_exp[idx] | !held;
      check(st[DPS_ST_OK_BIT], !held);
      check(st[15:8], own_exp);
      check(dps_dev_model_i.lreq, own_exp);
      if (held) rsem(idx, 1'b1);
    end
    $display("test random acquire done");
    for (int i = 0; i < 8; i++) begin
      wr(DPS_REG_CMD, cmd(DPS_OP_RELEASE, 3'(i), 1'b0));
      wait_idle();
      own_exp[i] = 1'b0;
      check(st[15:8], own_exp);
    end
    check(dps_dev_model_i.lreq, 8'h00);
    $display("test release done");
    rsem(3'h5, 1'b0);
    wr(DPS_REG_CMD, cmd(DPS_OP_ACQUIRE, 3'h5, 1'b0));
    wr(DPS_REG_CMD, cmd(DPS_OP_RELEASE, 3'h5, 1'b0));
    repeat (120) @(posedge clk);
    rsem(3'h5, 1'b1);
    wait_idle();
    check(st[DPS_ST_OK_BIT], 1'b1);
    check(st[15:8], 8'h20);
    $display("test pending handover done");
    wd = 8'($random(seed));
    // The address is fixed first so the register write and the right port agree on it.
    ra = 15'($random(seed)) & 15'h000f;
    r_addr <= ra;
    r_ce <= 1'b1;
    wr(DPS_REG_ADDR, 32'(ra));
    wr(DPS_REG_WDATA, 32'(wd));
    wr(DPS_REG_CMD, cmd(DPS_OP_MEM_WRITE, 3'h0, 1'b0));
    repeat (200) @(posedge clk);
    // Looked at after the edge: the access must still stand with the strobe held off.
    #1 check({pins.chip_enable_n, pins.read_write_n}, 2'b01);
    r_ce <= 1'b0;
    wait_idle();
    check(st[DPS_ST_BUSY_BIT], 1'b1);
    check(dps_dev_model_i.mem[ra[3:0]], wd);
    wr(DPS_REG_CMD, cmd(DPS_OP_MEM_READ, 3'h0, 1'b0));
    wait_idle();
    check(st[23:16], wd);
    $display("test busy write done");
    give_verdict();
  end
endmodule // testbench
`default_nettype wire
